// ==== rtl/vmoc_pkg.sv ====
// Package for the VME master ownership control block.
// Assumes a single 20 MHz clock and a 32-bit register port.
package vmoc_pkg;
  localparam logic [11:0] MASTER_CONTROL_OFS = 12'h0400;
  localparam int RETRY_LSB = 28;
  localparam int PWCNT_LSB = 24;
  localparam int VRL_LSB = 22;
  localparam int VRM_BIT = 21;
  localparam int VREL_BIT = 20;
  localparam int HOLD_BIT = 19;
  localparam int HOLD_ACK_BIT = 18;
  localparam int PABS_LSB = 12;
  localparam int BUSNO_LSB = 0;
  localparam logic [3:0] RETRY_RESET = 4'h8;
  localparam logic [3:0] PWCNT_RESET = 4'h0;
  localparam logic [1:0] VRL_RESET = 2'h3;
  localparam logic [3:0] PWCNT_EVERY = 4'hf;
  localparam logic [3:0] PWCNT_MAX_CODE = 4'h5;
  localparam int PWCNT_BASE_SHIFT = 7;
  localparam int RETRY_SHIFT = 6;
  localparam int CNT_W = 13;
  localparam int RETRY_W = 10;
  typedef enum logic [1:0] {VM_IDLE, VM_REQ, VM_OWN} vmoc_state_e;
endpackage

// ==== rtl/vmoc_byte_counter.sv ====
// Counts posted-write bytes drained while pw_active is high.
// Assumes byte counts per beat are 1 to 8 and arrive synchronously.
`timescale 1ns/1ns
module vmoc_byte_counter #(
  parameter int CNT_W = 13
) (
  // Clock
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  input wire logic beat,
  input wire logic [3:0] beat_bytes,
  input wire logic [CNT_W-1:0] limit,
  // Status
  output logic reached_q
);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W:0] sum;
  assign sum = {1'b0, count_q} + {{(CNT_W-3){1'b0}}, beat_bytes};
  initial begin
    if (CNT_W < 13) $error("CNT_W too small");
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      reached_q <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        count_q <= '0;
        reached_q <= 1'b0;
      end else if (beat) begin
        count_q <= sum[CNT_W-1:0];
        reached_q <= (sum >= {1'b0, limit});
      end
    end
  end
endmodule

// ==== rtl/vmoc_top.sv ====
// Master control register and VMEbus ownership logic of a bridge.
// Assumes register writes from PCI and VME arrive as one-cycle strobes.
`timescale 1ns/1ns
// Operation
// RULE_01 - Hold bit set asserts bus-busy until software writes zero.
// RULE_02 - Holding the bus does not disturb PCI target channel traffic.
// RULE_03 - Bus held by hold bit never releases bus-busy early.
// RULE_04 - Software waits for acknowledge zero before setting hold bit.
// RULE_05 - On bus error while held, software clears the hold bit.
// RULE_06 - VME-side masters never write one to the hold bit.
// RULE_07 - Posted write drain releases bus-busy early at programmed count.
// RULE_08 - Count code 0 is 128 bytes doubling to code 5; resets zero.
// RULE_09 - Count code 1111 releases bus-busy after every transaction.
// RULE_10 - Config cycle is Type 0 when address[23:16] matches bus number.
// RULE_11 - Retry limit 0 is forever, else value times 64; resets 8.
// RULE_12 - Acknowledge reads one only when bus held by hold bit.
// RULE_13 - Hold bit requests through arbitration; acknowledge after grant.
module vmoc_top #(
  parameter int CNT_W = vmoc_pkg::CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_from_vme,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  // VMEbus arbitration
  output logic bus_request_q,
  input wire logic bus_grant,
  output logic bus_busy_q,
  // Posted write drain
  input wire logic pw_active,
  input wire logic pw_beat,
  input wire logic [3:0] pw_beat_bytes,
  input wire logic pw_xfer_end,
  // Configuration mapping
  input wire logic [7:0] cfg_addr_bus,
  output logic cfg_type1_q,
  // PCI master retry
  input wire logic pci_retry,
  input wire logic pci_xfer_done,
  output logic pci_retry_error_q
);
  logic [3:0] retry_q;
  logic [3:0] pwcnt_q;
  logic [1:0] vrl_q;
  logic vrm_q;
  logic vrel_q;
  logic hold_q;
  logic hold_ack_q;
  logic [1:0] pabs_q;
  logic [7:0] bus_no_q;
  localparam int RETRY_W_L = vmoc_pkg::RETRY_W;
  logic [RETRY_W_L-1:0] retry_cnt_q;
  vmoc_pkg::vmoc_state_e state_q;
  vmoc_pkg::vmoc_state_e state_d;
  initial begin
    if (CNT_W < vmoc_pkg::CNT_W) $error("CNT_W too small");
  end

  // Register decode
  wire ctl_hit = (reg_addr == vmoc_pkg::MASTER_CONTROL_OFS);
  wire ctl_wr = reg_wr && ctl_hit;
  wire ctl_we = clk_en && ctl_wr;
  wire [3:0] w_retry = reg_wdata[vmoc_pkg::RETRY_LSB +: 4];
  wire [3:0] w_pwcnt = reg_wdata[vmoc_pkg::PWCNT_LSB +: 4];
  wire [1:0] w_vrl = reg_wdata[vmoc_pkg::VRL_LSB +: 2];
  wire w_vrm = reg_wdata[vmoc_pkg::VRM_BIT];
  wire w_vrel = reg_wdata[vmoc_pkg::VREL_BIT];
  wire w_hold = reg_wdata[vmoc_pkg::HOLD_BIT];
  wire [1:0] w_pabs = reg_wdata[vmoc_pkg::PABS_LSB +: 2];
  wire [7:0] w_bus_no = reg_wdata[vmoc_pkg::BUSNO_LSB +: 8];
  // VME-side writes of one are refused to avoid bus lockup
  wire hold_wr = ctl_wr && !(reg_from_vme && w_hold); // RULE_06
  // Reserved bits read as zero
  wire [31:0] ctl_word = {retry_q, pwcnt_q, vrl_q, vrm_q, vrel_q, hold_q,
    hold_ack_q, 4'h0, pabs_q, 4'h0, bus_no_q};

  // Early release threshold: 128 bytes shifted by code
  wire [CNT_W-1:0] pw_limit = CNT_W'(1 << (vmoc_pkg::PWCNT_BASE_SHIFT
    + int'(pwcnt_q))); // RULE_08
  // Reserved codes never reach a threshold
  wire pw_code_ok = (pwcnt_q <= vmoc_pkg::PWCNT_MAX_CODE);
  wire pw_reached;
  wire early_every = (pwcnt_q == vmoc_pkg::PWCNT_EVERY)
    && pw_xfer_end; // RULE_09
  wire early_count = pw_code_ok && pw_reached; // RULE_07
  // The hold bit overrides any release count
  wire early_rel = pw_active && !hold_q
    && (early_every || early_count); // RULE_03

  vmoc_byte_counter #(.CNT_W(CNT_W)) u_cnt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(!pw_active || early_rel),
    .beat(pw_beat),
    .beat_bytes(pw_beat_bytes),
    .limit(pw_limit),
    .reached_q(pw_reached)
  );

  // Ownership state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      vmoc_pkg::VM_IDLE: begin
        if (hold_q || pw_active) state_d = vmoc_pkg::VM_REQ; // RULE_13
      end
      vmoc_pkg::VM_REQ: begin
        if (!hold_q && !pw_active) state_d = vmoc_pkg::VM_IDLE;
        else if (bus_grant) state_d = vmoc_pkg::VM_OWN; // RULE_13
      end
      vmoc_pkg::VM_OWN: begin
        if (hold_q) state_d = vmoc_pkg::VM_OWN; // RULE_01
        else if (!pw_active || early_rel) state_d = vmoc_pkg::VM_IDLE;
      end
      default: state_d = vmoc_pkg::VM_IDLE;
    endcase
  end

  // Retry limit and release count fields
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      retry_q <= vmoc_pkg::RETRY_RESET; // RULE_11
      pwcnt_q <= vmoc_pkg::PWCNT_RESET; // RULE_08
    end else if (ctl_we) begin
      retry_q <= w_retry;
      pwcnt_q <= w_pwcnt;
    end
  end

  // Arbitration fields, stored and read back only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vrl_q <= vmoc_pkg::VRL_RESET;
      vrm_q <= 1'b0;
      vrel_q <= 1'b0;
    end else if (ctl_we) begin
      vrl_q <= w_vrl;
      vrm_q <= w_vrm;
      vrel_q <= w_vrel;
    end
  end

  // Burst size and local bus number
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pabs_q <= 2'h0;
      bus_no_q <= 8'h00;
    end else if (ctl_we) begin
      pabs_q <= w_pabs;
      bus_no_q <= w_bus_no;
    end
  end

  // Hold bit; VME-side sets were refused in decode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 1'b0;
    end else if (clk_en && hold_wr) begin
      hold_q <= w_hold; // RULE_01
    end
  end

  // Bus ownership outputs
  wire req_d = (state_d == vmoc_pkg::VM_REQ);
  wire own_d = (state_d == vmoc_pkg::VM_OWN);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= vmoc_pkg::VM_IDLE;
      bus_request_q <= 1'b0;
      bus_busy_q <= 1'b0;
      hold_ack_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      bus_request_q <= req_d;
      bus_busy_q <= own_d; // RULE_01
      hold_ack_q <= hold_q && own_d; // RULE_12
    end
  end

  // Read data and configuration type
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0000_0000;
      cfg_type1_q <= 1'b0;
    end else if (clk_en) begin
      reg_rdata_q <= ctl_hit ? ctl_word : 32'h0000_0000;
      cfg_type1_q <= (cfg_addr_bus != bus_no_q); // RULE_10
    end
  end

  // PCI master retry limit; independent of hold state
  wire [RETRY_W_L-1:0] retry_lim = RETRY_W_L'(int'(retry_q)
    << vmoc_pkg::RETRY_SHIFT); // RULE_11
  wire retry_forever = (retry_q == 4'h0);
  wire [RETRY_W_L-1:0] retry_next = retry_cnt_q + RETRY_W_L'(1);
  wire retry_hit = !retry_forever && (retry_next >= retry_lim);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      retry_cnt_q <= '0;
      pci_retry_error_q <= 1'b0;
    end else if (clk_en) begin
      pci_retry_error_q <= 1'b0;
      if (pci_xfer_done) begin
        retry_cnt_q <= '0; // RULE_02
      end else if (pci_retry) begin
        if (retry_hit) begin
          pci_retry_error_q <= 1'b1; // RULE_11
          retry_cnt_q <= '0;
        end else begin
          retry_cnt_q <= retry_next;
        end
      end
    end
  end
endmodule

// ==== verif/vmoc_arb_model.sv ====
// Arbiter model: grants a pending bus request after a set lag.
// Assumes the request stays up until the grant has been seen.
`timescale 1ns/1ns
module vmoc_arb_model (
  // Clock, request and grant
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic [3:0] lag,
  output logic bus_grant_q
);
  logic [3:0] wait_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 4'h0;
      bus_grant_q <= 1'b0;
    end else begin
      bus_grant_q <= req && wait_q >= lag;
      wait_q <= req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== verif/vmoc_top_props.sv ====
// Checker of bus ownership and retry behaviour at the top ports.
// Assumes one clock domain; bound into every vmoc_top.
`timescale 1ns/1ns
module vmoc_top_props (
  // Clock and register port
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_from_vme,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_q,
  // Bus and retry
  input wire logic bus_request_q,
  input wire logic bus_grant,
  input wire logic bus_busy_q,
  input wire logic pw_active,
  input wire logic pci_retry,
  input wire logic pci_retry_error_q
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic at_mc = clk_en && reg_addr == vmoc_pkg::MASTER_CONTROL_OFS;
  wire logic hb = reg_wdata[vmoc_pkg::HOLD_BIT];
  wire logic set_h = reg_wr && at_mc && hb;
  wire logic clr_h = reg_wr && at_mc && !hb;
  wire logic idle = !bus_request_q && !bus_busy_q;
  logic held_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= 1'b0;
    end else if (reg_wr && at_mc && !(reg_from_vme && hb)) begin
      held_q <= hb;
    end
  end
  property p_req; set_h && !reg_from_vme && idle |-> ##[1:2] bus_request_q;
  endproperty
  a_req: assert property (p_req) else $error("no request");
  property p_vme;
    set_h && reg_from_vme && idle && !pw_active && !held_q
      |-> ##2 !bus_request_q;
  endproperty
  a_vme: assert property (p_vme) else $error("vme hold taken");
  property p_grant;
    clk_en && bus_request_q && bus_grant && (held_q || pw_active)
      |=> bus_busy_q;
  endproperty
  a_grant: assert property (p_grant) else $error("no busy");
  property p_rose; $rose(bus_busy_q) |-> $past(bus_grant); endproperty
  a_rose: assert property (p_rose) else $error("busy w/o grant");
  property p_rel; bus_busy_q && clr_h && !pw_active |-> ##[1:2] !bus_busy_q;
  endproperty
  a_rel: assert property (p_rel) else $error("busy kept");
  property p_stay; bus_busy_q && held_q && !clr_h |=> bus_busy_q;
  endproperty
  a_stay: assert property (p_stay) else $error("busy dropped");
  property p_retry; $rose(pci_retry_error_q) |-> $past(pci_retry); endproperty
  a_retry: assert property (p_retry) else $error("stray error");
  property p_ack;
    at_mc |=> reg_rdata_q[vmoc_pkg::HOLD_ACK_BIT]
      == ($past(bus_busy_q) && $past(held_q, 2));
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong");
endmodule
bind vmoc_top vmoc_top_props vmoc_top_props_inst (.*);

// ==== verif/tb.sv ====
// Testbench of the master control ownership block.
// Assumes the arbiter model is the only partner on the bus side.
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0;
  logic reg_from_vme = 1'b0, pw_active = 1'b0, pw_beat = 1'b0;
  logic pw_xfer_end = 1'b0, pci_retry = 1'b0, pci_xfer_done = 1'b0;
  logic bus_request_q, bus_grant, bus_busy_q, cfg_type1_q, pci_retry_error_q;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_q;
  logic [3:0] pw_beat_bytes = 4'h0, lag = 4'h0;
  logic [7:0] cfg_addr_bus = 8'h00;
  int err_count = 0, samples_checked = 0, n_fire = 0, n_cyc = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (pci_retry_error_q === 1'b1) n_fire <= n_fire + 1;
  vmoc_top vmoc_top_inst (.*);
  vmoc_arb_model vmoc_arb_model_inst (.sys_clk(sys_clk), .resetn(resetn),
    .req(bus_request_q), .lag(lag), .bus_grant_q(bus_grant));
  task chk(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [31:0] d, input logic v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_from_vme <= v;
    reg_addr <= vmoc_pkg::MASTER_CONTROL_OFS;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task rd(input logic [31:0] e, input logic [11:0] a = 12'h400);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1;
    chk(reg_rdata_q, e, "master_control");
  endtask
  task rtry(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      pci_retry <= 1'b1;
      @(posedge sys_clk);
      pci_retry <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    #400000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(32'h80C0_0000);
    rd(32'h0000_0000, 12'h404);
    $display("test reset done");
    clk_en <= 1'b0;
    wr(32'h0000_0000, 1'b0);
    clk_en <= 1'b1;
    rd(32'h80C0_0000);
    $display("test freeze done");
    for (int k = 0; k < 2; k++) begin
      lag <= k ? 4'h6 : 4'h0;
      wr({4'h8, k ? 4'hf : 4'h0, 24'hC8_0000}, 1'b0);
      for (int n = 0; n < 12 && bus_busy_q !== 1'b1; n++)
        @(posedge sys_clk);
      #1;
      chk(bus_busy_q, 1'b1, "bus_busy");
      rd({4'h8, k ? 4'hf : 4'h0, 24'hCC_0000});
      @(posedge sys_clk);
      pw_active <= 1'b1;
      pw_beat <= 1'b1;
      pw_beat_bytes <= 4'h8;
      repeat (20) @(posedge sys_clk);
      pw_beat <= 1'b0;
      pw_xfer_end <= 1'b1;
      @(posedge sys_clk);
      pw_xfer_end <= 1'b0;
      pw_active <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(bus_busy_q, 1'b1, "bus_busy drain");
      wr(32'h80C0_0000, 1'b0);
      chk(bus_busy_q, 1'b0, "bus_busy free");
      rd(32'h80C0_0000);
      $display("test hold %0d done", k);
    end
    wr(32'h13C8_0012, 1'b1);
    chk(bus_request_q, 1'b0, "bus_request");
    rd(32'h13C0_0012);
    for (int k = 0; k < 2; k++) begin
      wr(k ? 32'h1FC0_0012 : 32'h10C0_0012, 1'b0);
      pw_active <= 1'b1;
      n_cyc = 0;
      while (bus_busy_q !== 1'b1 && n_cyc < 20) begin
        @(posedge sys_clk);
        #1;
        n_cyc++;
      end
      chk(bus_busy_q, 1'b1, "bus_busy drain own");
      n_cyc = 0;
      @(posedge sys_clk);
      pw_beat <= 1'b1;
      pw_beat_bytes <= 4'h8;
      pw_xfer_end <= (k == 1);
      do begin
        @(posedge sys_clk);
        #1;
        pw_xfer_end <= 1'b0;
        n_cyc++;
      end while (bus_busy_q === 1'b1 && n_cyc < 40);
      pw_beat <= 1'b0;
      pw_active <= 1'b0;
      chk(n_cyc, k ? 1 : 17, "early release cycles");
    end
    $display("test early release done");
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      cfg_addr_bus <= 8'(8'h12 + k);
      @(posedge sys_clk);
      #1;
      chk(cfg_type1_q, k, "cfg_type1");
    end
    rtry(63);
    chk(n_fire, 0, "retry_error early");
    rtry(1);
    chk(n_fire, 1, "retry_error");
    rtry(40);
    pci_xfer_done <= 1'b1;
    @(posedge sys_clk);
    pci_xfer_done <= 1'b0;
    rtry(40);
    chk(n_fire, 1, "retry_error cleared");
    $display("test cfg and retry done");
    tally_and_finish;
  end
endmodule
